// file: design/ptg_pkg.sv
package ptg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_TOTAL_LO = 6'h04;  // Line length, low byte
  localparam logic [5:0] IDX_TOTAL_HI = 6'h05;  // Line length, high nibble
  localparam logic [5:0] IDX_HSW      = 6'h0a;  // Hsync width
  localparam logic [5:0] IDX_VSW      = 6'h0b;  // Vsync width
  localparam logic [5:0] IDX_HBP      = 6'h0c;  // Horizontal back porch
  localparam logic [5:0] IDX_VBP      = 6'h0d;  // Vertical back porch
  localparam logic [5:0] IDX_SYNC     = 6'h0e;  // Sync control
  localparam logic [5:0] IDX_FTIME    = 6'h0f;  // Scroll frame time
  localparam logic [5:0] IDX_SLOTS    = 6'h10;  // Enabled slot count
  localparam logic [5:0] IDX_TS12     = 6'h11;  // Slots 1 and 2
  localparam logic [5:0] IDX_TS34     = 6'h12;  // Slots 3 and 4
  localparam logic [5:0] IDX_TS56     = 6'h13;  // Slots 5 and 6
  localparam logic [5:0] IDX_CTRL     = 6'h20;  // Enable and mode
  localparam logic [5:0] IDX_FLN_LO   = 6'h21;  // Frame lines, low byte
  localparam logic [5:0] IDX_FLN_HI   = 6'h22;  // Frame lines, high nibble
  localparam logic [5:0] IDX_STATUS   = 6'h23;  // Slot and pattern now shown
  // Reset values
  localparam logic [7:0] RST_TOTAL_LO = 8'h48;
  localparam logic [3:0] RST_TOTAL_HI = 4'h3;
  localparam logic [7:0] RST_HSW      = 8'h0a;
  localparam logic [7:0] RST_VSW      = 8'h02;
  localparam logic [7:0] RST_HBP      = 8'h0a;
  localparam logic [7:0] RST_VBP      = 8'h02;
  localparam logic [2:0] RST_SYNC     = 3'h3;
  localparam logic [7:0] RST_FTIME    = 8'h1e;
  localparam logic [4:0] RST_SLOTS    = 5'h0c;
  localparam logic [7:0] RST_TS12     = 8'h21;
  localparam logic [7:0] RST_TS34     = 8'h43;
  localparam logic [7:0] RST_TS56     = 8'h65;
  localparam logic [2:0] RST_CTRL     = 3'h0;
  localparam logic [11:0] RST_FLINES  = 12'h1e5;
  // Field positions
  localparam int SYNC_HINV = 0;  // hsync_invert
  localparam int SYNC_VINV = 1;  // vsync_invert
  localparam int SYNC_HOFF = 2;  // hsync_suppress
  localparam int CTRL_EN   = 0;  // Generator enable
  localparam int CTRL_EXT  = 1;  // External timing mode
  localparam int CTRL_SCR  = 2;  // Auto-scroll enable
  localparam logic [4:0] MAX_SLOTS = 5'h10;  // Largest slot count
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/ptg_scroll.sv
`timescale 1ns/1ps
`default_nettype none
module ptg_scroll (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic        frame_tick,
  input  wire logic [7:0]  frames_per_pattern_half,
  input  wire logic [4:0]  enabled_slot_count,
  input  wire logic [63:0] slot_patterns,
  output logic      [3:0]  slot_q,
  output logic      [3:0]  pattern_q
);
  logic [8:0] frame_q;  // Frames shown of the current slot
  logic [8:0] frame_d;
  logic [3:0] slot_d;
  logic [3:0] pattern_d;
  logic [8:0] hold_last;  // Last frame index of a slot
  logic [3:0] last_slot;  // Zero-based last enabled slot

  // Zero-based index of the last slot, clamped into 1..16 slots
  function automatic logic [3:0] last_of(input logic [4:0] cnt);
    if (cnt == 5'h00) return 4'h0;
    else if (cnt > ptg_pkg::MAX_SLOTS) return 4'hf;
    else return 4'(cnt - 5'h01);
  endfunction

  // Pattern selector held by a slot, two slots per byte
  function automatic logic [3:0] pick(input logic [63:0] p, input logic [3:0] s);
    return p[{s, 2'h0} +: 4];
  endfunction

  // Frame and slot stepping
  always_comb begin
    hold_last = {frames_per_pattern_half, 1'b0} - 9'h001;
    last_slot = last_of(enabled_slot_count);
    frame_d   = frame_q;
    slot_d    = slot_q;
    if (!run) begin
      // Idle: restart at slot one
      frame_d = 9'h000;
      slot_d  = 4'h0;
    end else if (frame_tick) begin
      if (frame_q >= hold_last) begin
        frame_d = 9'h000;
        // Step upward and wrap after the last enabled slot
        slot_d = (slot_q >= last_slot) ? 4'h0 : slot_q + 4'h1;
      end else begin
        frame_d = frame_q + 9'h001;
      end
    end
    pattern_d = pick(slot_patterns, slot_d);
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_q   <= 9'h000;
      slot_q    <= 4'h0;
      pattern_q <= 4'h0;
    end else begin
      frame_q   <= frame_d;
      slot_q    <= slot_d;
      pattern_q <= pattern_d;
    end
  end

  a_hold_frames: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run && frame_tick && frame_q < hold_last |=> slot_q == $past(slot_q))
    else $error("Slot changed before its frame time ran out");

  a_slot_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run && frame_tick && frame_q >= hold_last && slot_q < last_slot
    |=> slot_q == $past(slot_q) + 4'h1)
    else $error("Slot did not step up by one");

  a_slot_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run && frame_tick && frame_q >= hold_last && slot_q >= last_slot
    |=> slot_q == 4'h0)
    else $error("Slot did not wrap to slot one");

  a_slot_pattern: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run |=> pattern_q == pick($past(slot_patterns), slot_q))
    else $error("Pattern does not match current slot");
endmodule
`default_nettype wire

// file: design/ptg_timing_top.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ptg_timing_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_hsync,
  input  wire logic        ext_vsync,
  input  wire logic [39:0] upper_slot_patterns,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             hback_porch_active,
  output logic             vback_porch_active,
  output logic [3:0]       pattern_sel
);
  // Configuration registers
  logic [7:0]  total_lo_q, total_lo_d;  // total_line_pixels[7:0]
  logic [3:0]  total_hi_q, total_hi_d;  // total_line_pixels[11:8]
  logic [7:0]  hsw_q, hsw_d;            // hsync_pulse_pixels
  logic [7:0]  vsw_q, vsw_d;            // vsync_pulse_lines
  logic [7:0]  hbp_q, hbp_d;            // hback_porch_pixels
  logic [7:0]  vbp_q, vbp_d;            // vback_porch_lines
  logic [2:0]  sync_q, sync_d;          // Suppress and invert bits
  logic [7:0]  ftime_q, ftime_d;        // frames_per_pattern_half
  logic [4:0]  slots_q, slots_d;        // enabled_slot_count
  logic [7:0]  ts12_q, ts12_d;          // slot1_pattern, slot2_pattern
  logic [7:0]  ts34_q, ts34_d;          // slot3_pattern, slot4_pattern
  logic [7:0]  ts56_q, ts56_d;          // slot5_pattern, slot6_pattern
  logic [2:0]  ctrl_q, ctrl_d;          // Enable, external, scroll
  logic [11:0] flines_q, flines_d;      // Lines per frame
  // Bus state
  logic        aw_have_q, aw_have_d;    // Write address held
  logic [5:0]  aw_idx_q, aw_idx_d;      // Held write index
  logic        w_have_q, w_have_d;      // Write data held
  logic [7:0]  wbyte_q, wbyte_d;        // Held write byte
  logic        wlane_q, wlane_d;        // Held strobe of lane 0
  logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  // Timing state
  logic [11:0] hcnt_q, hcnt_d;          // Pixel within line
  logic [11:0] vcnt_q, vcnt_d;          // Line within frame
  logic [2:0]  hs_pipe_q, hs_pipe_d;    // Hsync pin synchroniser
  logic [2:0]  vs_pipe_q, vs_pipe_d;    // Vsync pin synchroniser
  logic        ext_hs_q, ext_hs_d;      // Settled external hsync
  logic        ext_vs_q, ext_vs_d;      // Settled external vsync
  logic        tick_q, tick_d;          // Frame start pulse
  logic        hsync_d, vsync_d, hbp_act_d, vbp_act_d;
  logic        run_int;                 // Internal timing running
  logic [11:0] total, h_bp_end, v_bp_end;
  logic        hs_raw, vs_raw, line_end;
  logic [3:0]  cur_slot;                // Slot now shown, zero-based

  // Decoded indices that exist
  function automatic logic mapped(input logic [5:0] idx);
    case (idx)
      ptg_pkg::IDX_TOTAL_LO, ptg_pkg::IDX_TOTAL_HI, ptg_pkg::IDX_HSW,
      ptg_pkg::IDX_VSW, ptg_pkg::IDX_HBP, ptg_pkg::IDX_VBP,
      ptg_pkg::IDX_SYNC, ptg_pkg::IDX_FTIME, ptg_pkg::IDX_SLOTS,
      ptg_pkg::IDX_TS12, ptg_pkg::IDX_TS34, ptg_pkg::IDX_TS56,
      ptg_pkg::IDX_CTRL, ptg_pkg::IDX_FLN_LO, ptg_pkg::IDX_FLN_HI,
      ptg_pkg::IDX_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Register file and bus handshakes
  always_comb begin
    total_lo_d = total_lo_q;
    total_hi_d = total_hi_q;
    hsw_d      = hsw_q;
    vsw_d      = vsw_q;
    hbp_d      = hbp_q;
    vbp_d      = vbp_q;
    sync_d     = sync_q;
    ftime_d    = ftime_q;
    slots_d    = slots_q;
    ts12_d     = ts12_q;
    ts34_d     = ts34_q;
    ts56_d     = ts56_q;
    ctrl_d     = ctrl_q;
    flines_d   = flines_q;
    aw_have_d  = aw_have_q;
    aw_idx_d   = aw_idx_q;
    w_have_d   = w_have_q;
    wbyte_d    = wbyte_q;
    wlane_d    = wlane_q;
    bvalid_d   = s_axi_bvalid;
    bresp_d    = s_axi_bresp;
    rvalid_d   = s_axi_rvalid;
    rresp_d    = s_axi_rresp;
    rdata_d    = s_axi_rdata;
    // Address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_idx_d  = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Both halves present: store and answer
    if (aw_have_d && w_have_d && !s_axi_bvalid) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(aw_idx_d) ? ptg_pkg::RESP_OKAY : ptg_pkg::RESP_SLVERR;
      if (wlane_d) begin
        case (aw_idx_d)
          ptg_pkg::IDX_TOTAL_LO: total_lo_d = wbyte_d;
          ptg_pkg::IDX_TOTAL_HI: total_hi_d = wbyte_d[3:0];
          ptg_pkg::IDX_HSW:    hsw_d    = wbyte_d;
          ptg_pkg::IDX_VSW:    vsw_d    = wbyte_d;
          ptg_pkg::IDX_HBP:    hbp_d    = wbyte_d;
          ptg_pkg::IDX_VBP:    vbp_d    = wbyte_d;
          ptg_pkg::IDX_SYNC:   sync_d   = wbyte_d[2:0];
          ptg_pkg::IDX_FTIME:  ftime_d  = wbyte_d;
          ptg_pkg::IDX_SLOTS:  slots_d  = wbyte_d[4:0];
          ptg_pkg::IDX_TS12:   ts12_d   = wbyte_d;
          ptg_pkg::IDX_TS34:   ts34_d   = wbyte_d;
          ptg_pkg::IDX_TS56:   ts56_d   = wbyte_d;
          ptg_pkg::IDX_CTRL:   ctrl_d   = wbyte_d[2:0];
          ptg_pkg::IDX_FLN_LO: flines_d = {flines_q[11:8], wbyte_d};
          ptg_pkg::IDX_FLN_HI: flines_d = {wbyte_d[3:0], flines_q[7:0]};
          default: ;  // Status and holes ignore writes
        endcase
      end
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    // Read channel: answer one cycle after the address
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr[7:2]) ? ptg_pkg::RESP_OKAY : ptg_pkg::RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr[7:2])
        ptg_pkg::IDX_TOTAL_LO: rdata_d[7:0] = total_lo_q;
        ptg_pkg::IDX_TOTAL_HI: rdata_d[3:0] = total_hi_q;
        ptg_pkg::IDX_HSW:    rdata_d[7:0] = hsw_q;
        ptg_pkg::IDX_VSW:    rdata_d[7:0] = vsw_q;
        ptg_pkg::IDX_HBP:    rdata_d[7:0] = hbp_q;
        ptg_pkg::IDX_VBP:    rdata_d[7:0] = vbp_q;
        ptg_pkg::IDX_SYNC:   rdata_d[2:0] = sync_q;
        ptg_pkg::IDX_FTIME:  rdata_d[7:0] = ftime_q;
        ptg_pkg::IDX_SLOTS:  rdata_d[4:0] = slots_q;
        ptg_pkg::IDX_TS12:   rdata_d[7:0] = ts12_q;
        ptg_pkg::IDX_TS34:   rdata_d[7:0] = ts34_q;
        ptg_pkg::IDX_TS56:   rdata_d[7:0] = ts56_q;
        ptg_pkg::IDX_CTRL:   rdata_d[2:0] = ctrl_q;
        ptg_pkg::IDX_FLN_LO: rdata_d[7:0] = flines_q[7:0];
        ptg_pkg::IDX_FLN_HI: rdata_d[3:0] = flines_q[11:8];
        ptg_pkg::IDX_STATUS: rdata_d[7:0] = {cur_slot, pattern_sel};
        default: ;  // Holes read zero
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Register file flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_lo_q <= ptg_pkg::RST_TOTAL_LO;
      total_hi_q <= ptg_pkg::RST_TOTAL_HI;
      hsw_q      <= ptg_pkg::RST_HSW;
      vsw_q      <= ptg_pkg::RST_VSW;
      hbp_q      <= ptg_pkg::RST_HBP;
      vbp_q      <= ptg_pkg::RST_VBP;
      sync_q     <= ptg_pkg::RST_SYNC;
      ftime_q    <= ptg_pkg::RST_FTIME;
      slots_q    <= ptg_pkg::RST_SLOTS;
      ts12_q     <= ptg_pkg::RST_TS12;
      ts34_q     <= ptg_pkg::RST_TS34;
      ts56_q     <= ptg_pkg::RST_TS56;
      ctrl_q     <= ptg_pkg::RST_CTRL;
      flines_q   <= ptg_pkg::RST_FLINES;
      aw_have_q  <= 1'b0;
      aw_idx_q   <= 6'h00;
      w_have_q   <= 1'b0;
      wbyte_q    <= 8'h00;
      wlane_q    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      total_lo_q <= total_lo_d;
      total_hi_q <= total_hi_d;
      hsw_q      <= hsw_d;
      vsw_q      <= vsw_d;
      hbp_q      <= hbp_d;
      vbp_q      <= vbp_d;
      sync_q     <= sync_d;
      ftime_q    <= ftime_d;
      slots_q    <= slots_d;
      ts12_q     <= ts12_d;
      ts34_q     <= ts34_d;
      ts56_q     <= ts56_d;
      ctrl_q     <= ctrl_d;
      flines_q   <= flines_d;
      aw_have_q  <= aw_have_d;
      aw_idx_q   <= aw_idx_d;
      w_have_q   <= w_have_d;
      wbyte_q    <= wbyte_d;
      wlane_q    <= wlane_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rresp   <= rresp_d;
      s_axi_rdata   <= rdata_d;
    end
  end

  // Raster counters, sync shaping and pin synchronisers
  always_comb begin
    run_int  = ctrl_q[ptg_pkg::CTRL_EN] && !ctrl_q[ptg_pkg::CTRL_EXT];
    total    = {total_hi_q, total_lo_q};
    h_bp_end = 12'(hsw_q) + 12'(hbp_q);
    v_bp_end = 12'(vsw_q) + 12'(vbp_q);
    line_end = hcnt_q >= total - 12'h001;
    hs_raw   = hcnt_q < 12'(hsw_q);
    vs_raw   = vcnt_q < 12'(vsw_q);
    hcnt_d   = 12'h000;
    vcnt_d   = 12'h000;
    if (run_int) begin
      hcnt_d = line_end ? 12'h000 : hcnt_q + 12'h001;
      vcnt_d = vcnt_q;
      if (line_end) begin
        vcnt_d = (vcnt_q >= flines_q - 12'h001) ? 12'h000 : vcnt_q + 12'h001;
      end
    end
    // Only the second and third stages are compared
    hs_pipe_d = {hs_pipe_q[1:0], ext_hsync};
    vs_pipe_d = {vs_pipe_q[1:0], ext_vsync};
    ext_hs_d  = (hs_pipe_q[1] == hs_pipe_q[2]) ? hs_pipe_q[2] : ext_hs_q;
    ext_vs_d  = (vs_pipe_q[1] == vs_pipe_q[2]) ? vs_pipe_q[2] : ext_vs_q;
    hsync_d   = 1'b0;
    vsync_d   = 1'b0;
    hbp_act_d = 1'b0;
    vbp_act_d = 1'b0;
    tick_d    = 1'b0;
    if (run_int) begin
      // Internal timing: suppress and invert apply
      hsync_d = sync_q[ptg_pkg::SYNC_HOFF] ? sync_q[ptg_pkg::SYNC_HINV]
                : hs_raw ^ sync_q[ptg_pkg::SYNC_HINV];
      vsync_d = vs_raw ^ sync_q[ptg_pkg::SYNC_VINV];
      hbp_act_d = !hs_raw && hcnt_q < h_bp_end;
      vbp_act_d = !vs_raw && vcnt_q < v_bp_end;
      tick_d = line_end && vcnt_q >= flines_q - 12'h001;
    end else if (ctrl_q[ptg_pkg::CTRL_EN]) begin
      // External timing passes the pins through untouched
      hsync_d = ext_hs_q;
      vsync_d = ext_vs_q;
      tick_d  = ext_vs_d && !ext_vs_q;
    end
  end

  // Raster flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcnt_q    <= 12'h000;
      vcnt_q    <= 12'h000;
      hs_pipe_q <= 3'h0;
      vs_pipe_q <= 3'h0;
      ext_hs_q  <= 1'b0;
      ext_vs_q  <= 1'b0;
      tick_q    <= 1'b0;
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      hback_porch_active <= 1'b0;
      vback_porch_active <= 1'b0;
    end else begin
      hcnt_q    <= hcnt_d;
      vcnt_q    <= vcnt_d;
      hs_pipe_q <= hs_pipe_d;
      vs_pipe_q <= vs_pipe_d;
      ext_hs_q  <= ext_hs_d;
      ext_vs_q  <= ext_vs_d;
      tick_q    <= tick_d;
      hsync_out <= hsync_d;
      vsync_out <= vsync_d;
      hback_porch_active <= hbp_act_d;
      vback_porch_active <= vbp_act_d;
    end
  end

  // Auto-scroll sequencer; its pattern output is a flop
  ptg_scroll u_scroll (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .run                     (ctrl_q[ptg_pkg::CTRL_EN] && ctrl_q[ptg_pkg::CTRL_SCR]),
    .frame_tick              (tick_q),
    .frames_per_pattern_half (ftime_q),
    .enabled_slot_count      (slots_q),
    .slot_patterns           ({upper_slot_patterns, ts56_q, ts34_q, ts12_q}),
    .slot_q                  (cur_slot),
    .pattern_q               (pattern_sel)
  );

  a_vsync_on: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_int && vcnt_q < 12'(vsw_q)
    |=> vsync_out == !$past(sync_q[ptg_pkg::SYNC_VINV]))
    else $error("Vsync not active within its width");

  a_vsync_end: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_int && vcnt_q == 12'(vsw_q)
    |=> vsync_out == $past(sync_q[ptg_pkg::SYNC_VINV]))
    else $error("Vsync still active after its width");

  a_hsync_width: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_int && !sync_q[ptg_pkg::SYNC_HOFF] && hcnt_q < 12'(hsw_q)
    |=> hsync_out == !$past(sync_q[ptg_pkg::SYNC_HINV]))
    else $error("Hsync wrong within its width");

  a_hsync_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_int && sync_q[ptg_pkg::SYNC_HOFF]
    |=> hsync_out == $past(sync_q[ptg_pkg::SYNC_HINV]))
    else $error("Hsync toggled while suppressed");

  a_hbp_span: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_int |=> hback_porch_active ==
      ($past(hcnt_q) >= 12'($past(hsw_q)) && $past(hcnt_q) < $past(h_bp_end)))
    else $error("Horizontal back porch span wrong");

  a_vbp_span: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_int |=> vback_porch_active ==
      ($past(vcnt_q) >= 12'($past(vsw_q)) && $past(vcnt_q) < $past(v_bp_end)))
    else $error("Vertical back porch span wrong");

  a_ext_pass: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ctrl_q[ptg_pkg::CTRL_EN] && ctrl_q[ptg_pkg::CTRL_EXT]
    |=> hsync_out == $past(ext_hs_q) && vsync_out == $past(ext_vs_q))
    else $error("External sync altered by control bits");

  a_line_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_int && hcnt_q == total - 12'h001 ##1 run_int |-> hcnt_q == 12'h000)
    else $error("Line did not end at its total width");
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk, aresetn;                // Clock and active-low reset
  logic [7:0]  awaddr, araddr;               // Bus byte addresses
  logic        awvalid, wvalid, bready;      // Write channel controls
  logic        arvalid, rready;              // Read channel controls
  logic [31:0] wdata, rdata;                 // Bus data
  logic        awready, wready, bvalid;      // Write channel answers
  logic        arready, rvalid;              // Read channel answers
  logic [1:0]  bresp, rresp;                 // Response codes
  logic        ext_h, ext_v;                 // External timing pins
  logic [39:0] upper;                        // Patterns of slots 7 to 16
  logic        hs, vs, hbp_a, vbp_a;         // Video timing outputs
  logic [3:0]  psel;                         // Pattern now shown
  logic [31:0] d;                            // Read data
  logic [1:0]  r;                            // Read response
  logic [3:0]  p, q[$];                      // Pattern change record
  int          t[$], cyc, k, h, b, vw, vbw;  // Change times, widths
  int          mh, mv, mhb, mvb;             // Counts over one frame
  int          n_mismatch, compares;         // Verdict counters
  logic [7:0]  rst [9] = '{8'h02, 8'h0a, 8'h02, 8'h03, 8'h1e, 8'h0c, 8'h21, 8'h43, 8'h65};
  logic [7:0]  msk [9] = '{8'hff, 8'hff, 8'hff, 8'h07, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff};
  logic [2:0]  syn [3] = '{3'h0, 3'h3, 3'h4};
  ptg_timing_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_hsync(ext_h), .ext_vsync(ext_v), .upper_slot_patterns(upper),
    .hsync_out(hs), .vsync_out(vs), .hback_porch_active(hbp_a), .vback_porch_active(vbp_a),
    .pattern_sel(psel));
  // Clock of 25 ns and a free cycle count
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // Compare one value and count it
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write; each channel drops valid once taken
  task wr(input logic [5:0] i, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  // Bus read; data taken at the edge that sees rvalid
  task rd(input logic [5:0] i);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      arvalid <= arvalid & ~arready;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // High cycles of each video output over one 256-cycle frame
  task meas();
    mh = 0;
    mv = 0;
    mhb = 0;
    mvb = 0;
    repeat (256) begin
      @(posedge aclk);
      mh += int'(hs);
      mv += int'(vs);
      mhb += int'(hbp_a);
      mvb += int'(vbp_a);
    end
  endtask
  // Expected sync high cycles for width w and unit u per frame
  function int ex_s(input logic inv, input logic off, input int w, input int u);
    return off ? (inv ? 256 : 0) : (inv ? 256 - u * w : u * w);
  endfunction
  // Pattern written for zero-based slot s in the scroll test
  function int slot_pat(input int s);
    return int'((24'h3b0c5a >> (4 * s)) & 24'h00000f);
  endfunction
  // Verdict and end of run
  task end_of_test();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_h, ext_v} = '0;
    {awaddr, araddr, wdata, cyc, n_mismatch, compares} = '0;
    void'($urandom(2));
    upper = 40'({$urandom(), $urandom()});
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values, random readback with reserved bits zero, unmapped index
    for (k = 0; k < 9; k++) begin
      rd(6'(ptg_pkg::IDX_VSW + k));
      chk("reset value", d, {24'h0, rst[k]});
      h = $urandom % 256;
      wr(6'(ptg_pkg::IDX_VSW + k), 8'(h));
      chk("write resp", {30'h0, r}, {30'h0, ptg_pkg::RESP_OKAY});
      rd(6'(ptg_pkg::IDX_VSW + k));
      chk("readback", d, {24'h0, 8'(h) & msk[k]});
    end
    rd(6'h3f);
    chk("unmapped resp", {30'h0, r}, {30'h0, ptg_pkg::RESP_SLVERR});
    wr(6'h3f, 8'h00);
    chk("unmapped bresp", {30'h0, r}, {30'h0, ptg_pkg::RESP_SLVERR});
    $display("test registers done");
    // Internal timing: 32-pixel lines, 8-line frames
    wr(ptg_pkg::IDX_CTRL, 8'h00);
    wr(ptg_pkg::IDX_TOTAL_LO, 8'h20);
    wr(ptg_pkg::IDX_TOTAL_HI, 8'h00);
    wr(ptg_pkg::IDX_FLN_LO, 8'h08);
    wr(ptg_pkg::IDX_FLN_HI, 8'h00);
    for (k = 0; k < 3; k++) begin
      h = 1 + $urandom % 6;
      b = 1 + $urandom % 6;
      vw = 1 + $urandom % 3;
      vbw = 1 + $urandom % 3;
      wr(ptg_pkg::IDX_CTRL, 8'h00);
      wr(ptg_pkg::IDX_HSW, 8'(h));
      wr(ptg_pkg::IDX_HBP, 8'(b));
      wr(ptg_pkg::IDX_VSW, 8'(vw));
      wr(ptg_pkg::IDX_VBP, 8'(vbw));
      wr(ptg_pkg::IDX_SYNC, {5'h0, syn[k]});
      wr(ptg_pkg::IDX_CTRL, 8'h01);
      repeat (300) @(posedge aclk);
      meas();
      chk("hsync cycles", mh, ex_s(syn[k][0], syn[k][2], h, 8));
      chk("vsync cycles", 32'(mv), 32'(ex_s(syn[k][1], 1'b0, vw, 32)));
      chk("hporch cycles", 32'(mhb), 32'(8 * b));
      chk("vporch cycles", 32'(mvb), 32'(32 * vbw));
    end
    $display("test internal timing done");
    // External timing: pins pass through, control bits ignored
    wr(ptg_pkg::IDX_CTRL, 8'h00);
    wr(ptg_pkg::IDX_SYNC, 8'h07);
    wr(ptg_pkg::IDX_CTRL, 8'h03);
    for (k = 0; k < 2; k++) begin
      ext_h <= k == 0;
      ext_v <= k == 1;
      repeat (10) @(posedge aclk);
      chk("ext hsync", {31'h0, hs}, 32'(k == 0));
      chk("ext vsync", {31'h0, vs}, 32'(k == 1));
    end
    $display("test external timing done");
    // Auto-scroll over six slots, two frames of 64 cycles each
    wr(ptg_pkg::IDX_CTRL, 8'h00);
    wr(ptg_pkg::IDX_TOTAL_LO, 8'h08);
    wr(ptg_pkg::IDX_FTIME, 8'h01);
    wr(ptg_pkg::IDX_SLOTS, 8'h06);
    wr(ptg_pkg::IDX_TS12, 8'h5a);
    wr(ptg_pkg::IDX_TS34, 8'h0c);
    wr(ptg_pkg::IDX_TS56, 8'h3b);
    p = psel;
    wr(ptg_pkg::IDX_CTRL, 8'h05);
    repeat (1200) begin
      @(posedge aclk);
      if (psel !== p) begin
        q.push_back(psel);
        t.push_back(cyc);
        p = psel;
      end
    end
    for (k = 0; k < 7; k++) begin
      chk("scroll pattern", 32'(q[k]), slot_pat((k + 1) % 6));
    end
    chk("scroll hold", 32'(t[2] - t[1]), 32'd128);
    $display("test scroll done");
    end_of_test();
  end
endmodule
`default_nettype wire
